// ==== core/mrad_pkg.sv ====
// memory region attribute decoder: shared types, region map, attributes
// assumes a 32-bit flat address space and one core clock domain
package mrad_pkg;

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   localparam int ADDR_W = 32;
   localparam int DATA_W = 32;
   localparam int REG_MSB = 31;
   localparam int REG_LSB = 29;
   localparam int PPB_LSB = 20;
   localparam logic [2:0] SEG_CODE = 3'h0;
   localparam logic [2:0] SEG_SRAM = 3'h1;
   localparam logic [2:0] SEG_PERIPH = 3'h2;
   localparam logic [2:0] SEG_XRAM_WBA = 3'h3;
   localparam logic [2:0] SEG_XRAM_WT = 3'h4;
   localparam logic [2:0] SEG_XDEV_SH = 3'h5;
   localparam logic [2:0] SEG_XDEV_NSH = 3'h6;
   localparam logic [2:0] SEG_SYSTEM = 3'h7;
   localparam logic [11:0] PPB_TAG = 12'hE00;

   // ----------------------------------------------------------------
   // attribute types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      MRAD_NORMAL = 2'h0,
      MRAD_DEVICE = 2'h1,
      MRAD_STRONG = 2'h2
   } mrad_mtype_e;

   typedef enum logic [1:0] {
      MRAD_CACHE_NONE = 2'h0,
      MRAD_WRITE_BACK_ALLOCATE = 2'h1,
      MRAD_WRITE_THROUGH = 2'h2
   } mrad_cache_e;

   typedef enum logic [2:0] {
      MRAD_RG_CODE = 3'h0,
      MRAD_RG_SRAM = 3'h1,
      MRAD_RG_PERIPH = 3'h2,
      MRAD_RG_XRAM = 3'h3,
      MRAD_RG_XDEV = 3'h4,
      MRAD_RG_PRIVATE_PERIPHERAL_RANGE = 3'h5,
      MRAD_RG_VENDOR = 3'h6,
      MRAD_RG_MPU = 3'h7
   } mrad_region_e;

   typedef struct packed {
      mrad_region_e region;
      mrad_mtype_e mtype;
      logic shareable;
      mrad_cache_e cache;
      logic execute_never;
   } mrad_attr_s;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic write;
      logic fetch;
   } mrad_req_s;

   typedef struct packed {
      mrad_req_s req;
      mrad_attr_s attr;
   } mrad_bus_req_s;

   typedef enum logic [1:0] {
      MRAD_BAR_DATA_MEMORY = 2'h0,
      MRAD_BAR_DATA_SYNC = 2'h1,
      MRAD_BAR_INSTRUCTION_SYNC = 2'h2
   } mrad_barrier_e;

   // gray codes along idle -> dmb -> dsb -> isb
   typedef enum logic [1:0] {
      MRAD_ST_IDLE = 2'b00,
      MRAD_ST_DMB = 2'b01,
      MRAD_ST_DSB = 2'b11,
      MRAD_ST_ISB = 2'b10
   } mrad_state_e;

   localparam int WBUF_DEPTH = 4;
   localparam int OUTST_MAX = 7;

endpackage : mrad_pkg

// ==== core/mrad_attr_decode.sv ====
// default memory map attribute decode with protection-unit override
// assumes the override attributes are valid whenever i_mpu_hit is high
`timescale 1ns/1ps
`default_nettype none
module mrad_attr_decode
(
   input wire logic [mrad_pkg::ADDR_W-1:0] i_addr,
   input wire logic i_mpu_en,
   input wire logic i_mpu_hit,
   input wire mrad_pkg::mrad_attr_s i_mpu_attr,
   output mrad_pkg::mrad_attr_s o_attr
);
   import mrad_pkg::*;

   // ----------------------------------------------------------------
   // default region table
   // ----------------------------------------------------------------
   function automatic mrad_attr_s default_attr(logic [ADDR_W-1:0] a);
      mrad_attr_s r;
      r = '{MRAD_RG_CODE, MRAD_NORMAL, 1'b0, MRAD_CACHE_NONE, 1'b0};
      case (a[REG_MSB:REG_LSB])
         SEG_CODE: r.region = MRAD_RG_CODE; // [RL11]
         SEG_SRAM: r.region = MRAD_RG_SRAM; // [RL12]
         SEG_PERIPH: // [RL13]
            r = '{MRAD_RG_PERIPH, MRAD_DEVICE, 1'b0, MRAD_CACHE_NONE, 1'b1};
         SEG_XRAM_WBA: // [RL14]
            r = '{MRAD_RG_XRAM, MRAD_NORMAL, 1'b0,
                  MRAD_WRITE_BACK_ALLOCATE, 1'b0};
         SEG_XRAM_WT: // [RL14]
            r = '{MRAD_RG_XRAM, MRAD_NORMAL, 1'b0,
                  MRAD_WRITE_THROUGH, 1'b0};
         SEG_XDEV_SH: // [RL15]
            r = '{MRAD_RG_XDEV, MRAD_DEVICE, 1'b1, MRAD_CACHE_NONE, 1'b1};
         SEG_XDEV_NSH: // [RL15]
            r = '{MRAD_RG_XDEV, MRAD_DEVICE, 1'b0, MRAD_CACHE_NONE, 1'b1};
         default:
         begin
            if (a[REG_MSB:PPB_LSB] == PPB_TAG)
               r = '{MRAD_RG_PRIVATE_PERIPHERAL_RANGE, MRAD_STRONG, 1'b1,
                     MRAD_CACHE_NONE, 1'b1}; // [RL16]
            else
               r = '{MRAD_RG_VENDOR, MRAD_DEVICE, 1'b0,
                     MRAD_CACHE_NONE, 1'b1}; // [RL17]
         end
      endcase
      return r;
   endfunction : default_attr

   // ----------------------------------------------------------------
   // override and strong-order shareability
   // ----------------------------------------------------------------
   wire mrad_attr_s dflt = default_attr(i_addr); // [RL1] [RL23]
   wire logic use_mpu = i_mpu_en && i_mpu_hit;
   wire mrad_attr_s picked = use_mpu ? i_mpu_attr : dflt; // [RL18]

   always_comb
   begin
      o_attr = picked;
      if (picked.mtype == MRAD_STRONG)
         o_attr.shareable = 1'b1; // [RL6]
   end

endmodule : mrad_attr_decode
`default_nettype wire

// ==== core/mrad_wbuf_mem.sv ====
// small storage array for the device write buffer
// read data is registered: it shows the word at i_raddr one edge later
`timescale 1ns/1ps
`default_nettype none
module mrad_wbuf_mem
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
)
(
   input wire logic i_clk_sys,
   input wire logic i_we,
   input wire logic [$clog2(DEPTH)-1:0] i_waddr,
   input wire logic [WIDTH-1:0] i_wdata,
   input wire logic [$clog2(DEPTH)-1:0] i_raddr,
   output logic [WIDTH-1:0] o_rdata
);
   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge i_clk_sys)
   begin
      if (i_we)
         mem[i_waddr] <= i_wdata;
      o_rdata <= mem[i_raddr];
   end

endmodule : mrad_wbuf_mem
`default_nettype wire

// ==== core/mrad_top.sv ====
// memory access attribute decode, ordering, write buffer and barriers
// assumes one access request and one barrier request port from the core,
// one issue port to the system bus with in-order completion pulses
//
// Functional notes
// RL1 - whole 32-bit space maps to fixed regions
// RL2 - normal accesses may bypass and reorder
// RL3 - device accesses keep order with device/strong
// RL4 - strongly-ordered keeps order with everything
// RL5 - device writes buffered, strong writes never
// RL6 - strongly-ordered regions always shareable
// RL7 - execute-never fetch blocked, raises fault
// RL8 - normal accesses carry no ordering guarantee
// RL9 - same-shareability device accesses stay ordered
// RL10 - strong plus device/strong pair stays ordered
// RL11 - code range normal and executable
// RL12 - sram range normal and executable
// RL13 - peripheral range device, execute-never
// RL14 - external ram normal; write-back then write-through
// RL15 - external device: shareable then non-shareable
// RL16 - private peripheral range strong, shareable, execute-never
// RL17 - vendor top range device, execute-never
// RL18 - protection unit hit overrides default decode
// RL19 - data memory barrier drains before next issue
// RL20 - data sync barrier stalls until drained
// RL21 - instruction sync barrier forces refetch
// RL22 - software places barriers after code/map changes
// RL23 - attribute decode combinational from address
`timescale 1ns/1ps
`default_nettype none
module mrad_top
#(
   parameter int WBUF_DEPTH = mrad_pkg::WBUF_DEPTH,
   parameter int OUTST_MAX = mrad_pkg::OUTST_MAX
)
(
   input wire logic i_clk_sys,
   input wire logic i_nrst,
   // core access request
   input wire logic i_req_valid,
   input wire mrad_pkg::mrad_req_s i_req,
   output logic o_req_ready,
   output mrad_pkg::mrad_attr_s o_attr,
   output logic o_fetch_fault,
   // protection unit override
   input wire logic i_mpu_en,
   input wire logic i_mpu_hit,
   input wire mrad_pkg::mrad_attr_s i_mpu_attr,
   // barriers
   input wire logic i_bar_valid,
   input wire mrad_pkg::mrad_barrier_e i_bar_kind,
   output logic o_bar_ready,
   output logic o_bar_done,
   output logic o_exec_stall,
   output logic o_refetch,
   // system bus issue
   output logic o_bus_valid,
   output mrad_pkg::mrad_bus_req_s o_bus_req,
   input wire logic i_bus_ready,
   input wire logic i_bus_done
);
   import mrad_pkg::*;

   localparam int PW = $clog2(WBUF_DEPTH);
   localparam int CW = $clog2(WBUF_DEPTH + 1);
   localparam int OW = $clog2(OUTST_MAX + 1);
   localparam int BW = $bits(mrad_bus_req_s);
   localparam logic [CW-1:0] WB_FULL = CW'(WBUF_DEPTH);
   localparam logic [OW-1:0] OUT_FULL = OW'(OUTST_MAX);

   // refuse sizes the ring and counters cannot serve
   generate
      if (WBUF_DEPTH < 2 || (1 << PW) != WBUF_DEPTH)
         $error("write buffer depth must be a power of two, at least 2");
      if (OUTST_MAX < 1)
         $error("outstanding limit must be at least 1");
   endgenerate

   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------
   // assertion acts at once, release waits two edges
   logic rst_s1;
   logic rst_n;

   always_ff @(posedge i_clk_sys or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         rst_s1 <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_s1 <= 1'b1;
         rst_n <= rst_s1;
      end
   end

   // ----------------------------------------------------------------
   // attribute decode
   // ----------------------------------------------------------------
   mrad_attr_decode u_dec
   (
      .i_addr(i_req.addr),
      .i_mpu_en(i_mpu_en),
      .i_mpu_hit(i_mpu_hit),
      .i_mpu_attr(i_mpu_attr),
      .o_attr(o_attr)
   );

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   // barrier sequencer
   mrad_state_e state;
   mrad_state_e next_state;

   // write buffer ring
   logic [PW-1:0] wr_ptr;
   logic [PW-1:0] rd_ptr;
   logic [CW-1:0] wb_count;
   logic fresh;
   logic [BW-1:0] wb_rdata;

   // issued bus transactions not yet completed
   logic [OW-1:0] outst;
   // a strongly-ordered access is in flight
   logic so_busy;

   // ring pointer step, used at both ends of the buffer
   function automatic logic [PW-1:0] ptr_step(logic [PW-1:0] p,
                                              logic en);
      return en ? p + 1'b1 : p;
   endfunction : ptr_step

   // ----------------------------------------------------------------
   // classification of the incoming access
   // ----------------------------------------------------------------
   wire logic is_normal = o_attr.mtype == MRAD_NORMAL;
   wire logic is_device = o_attr.mtype == MRAD_DEVICE;
   wire logic is_strong = o_attr.mtype == MRAD_STRONG;

   wire logic xn_fetch = i_req.fetch && o_attr.execute_never;
   wire logic dev_write = is_device && i_req.write && !i_req.fetch;

   // buffer, stage and outstanding status
   wire logic wb_empty = wb_count == '0;
   wire logic wb_full = wb_count == WB_FULL;
   wire logic head_ok = !wb_empty && !fresh;

   wire logic stage_free = !o_bus_valid || i_bus_ready;
   wire logic bus_take = o_bus_valid && i_bus_ready;
   // a staged request still to be taken counts as well
   wire logic out_room = o_bus_valid ? outst < OUT_FULL - 1'b1
                                     : outst != OUT_FULL;
   wire logic all_quiet = !o_bus_valid && outst == '0 && wb_empty;

   wire logic st_idle = state == MRAD_ST_IDLE;
   wire logic gate_ok = st_idle && !so_busy && rst_n;

   // strong waits for every earlier access to finish
   wire logic go_strong = is_strong && all_quiet; // [RL4] [RL10]
   // device reads wait behind buffered device writes
   wire logic go_devrd = is_device && !dev_write && wb_empty; // [RL3] [RL9]
   // normal accesses may overtake buffered device writes
   wire logic go_normal = is_normal; // [RL2] [RL8]

   wire logic direct_ok = stage_free && out_room
                          && (go_strong || go_devrd || go_normal);

   wire logic push_ok = dev_write && !wb_full; // [RL5]

   wire logic req_ok = gate_ok
                       && (xn_fetch || (dev_write ? push_ok : direct_ok));

   assign o_req_ready = req_ok;

   // what a taken request does
   wire logic fire = i_req_valid && req_ok;
   wire logic do_fault = fire && xn_fetch; // [RL7]
   wire logic do_push = fire && !xn_fetch && dev_write; // [RL5]
   wire logic do_direct = fire && !xn_fetch && !dev_write;
   wire logic do_strong = do_direct && is_strong;

   // drain only when the direct path does not claim the stage
   wire logic do_pop = head_ok && stage_free && out_room && !so_busy
                       && !do_direct && rst_n; // [RL3]

   wire logic [PW-1:0] next_rd_ptr = ptr_step(rd_ptr, do_pop);
   wire logic [PW-1:0] next_wr_ptr = ptr_step(wr_ptr, do_push);

   wire mrad_bus_req_s new_req = '{i_req, o_attr};
   wire logic bus_load = do_direct || do_pop;
   // the stage keeps its request until the bus takes it
   wire logic stage_hold = o_bus_valid && !i_bus_ready;
   wire logic next_valid = bus_load || stage_hold;

   // ----------------------------------------------------------------
   // device write buffer
   // ----------------------------------------------------------------
   mrad_wbuf_mem #(.WIDTH(BW), .DEPTH(WBUF_DEPTH)) u_wbuf
   (
      .i_clk_sys(i_clk_sys),
      .i_we(do_push),
      .i_waddr(wr_ptr),
      .i_wdata(new_req),
      .i_raddr(next_rd_ptr),
      .o_rdata(wb_rdata)
   );

   always_ff @(posedge i_clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         wb_count <= '0;
         fresh <= 1'b0;
      end
      else
      begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         wb_count <= wb_count + CW'(do_push) - CW'(do_pop);
         // head written this edge is not readable until the next one
         fresh <= do_push && (wr_ptr == next_rd_ptr);
      end
   end

   // ----------------------------------------------------------------
   // bus issue stage and outstanding count
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         o_bus_valid <= 1'b0;
         o_bus_req <= '0;
      end
      else
      begin
         o_bus_valid <= next_valid;
         if (do_direct)
         begin
            o_bus_req <= new_req;
         end
         else if (do_pop)
         begin
            o_bus_req <= mrad_bus_req_s'(wb_rdata);
         end
      end
   end

   always_ff @(posedge i_clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         outst <= '0;
      end
      else
      begin
         outst <= outst + OW'(bus_take) - OW'(i_bus_done && outst != '0);
      end
   end

   // nothing follows a strong access until it has completed
   always_ff @(posedge i_clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         so_busy <= 1'b0;
      end
      else if (do_strong)
      begin
         so_busy <= 1'b1; // [RL4]
      end
      else if (all_quiet)
      begin
         so_busy <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // barrier sequencing
   // ----------------------------------------------------------------
   always_comb
   begin
      next_state = state;
      case (state)
         MRAD_ST_IDLE:
         begin
            if (i_bar_valid && rst_n)
            begin
               case (i_bar_kind)
                  MRAD_BAR_DATA_MEMORY: next_state = MRAD_ST_DMB;
                  MRAD_BAR_DATA_SYNC: next_state = MRAD_ST_DSB;
                  default: next_state = MRAD_ST_ISB;
               endcase
            end
         end
         MRAD_ST_DMB:
         begin
            if (all_quiet)
               next_state = MRAD_ST_IDLE; // [RL19]
         end
         MRAD_ST_DSB:
         begin
            if (all_quiet)
               next_state = MRAD_ST_IDLE; // [RL20]
         end
         default:
         begin
            next_state = MRAD_ST_IDLE; // [RL21]
         end
      endcase
   end

   assign o_bar_ready = st_idle && rst_n;
   // later instructions hold off while a sync barrier drains
   assign o_exec_stall = state == MRAD_ST_DSB; // [RL20]

   always_ff @(posedge i_clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= MRAD_ST_IDLE;
         o_bar_done <= 1'b0;
         o_refetch <= 1'b0;
         o_fetch_fault <= 1'b0;
      end
      else
      begin
         state <= next_state;
         o_bar_done <= !st_idle && next_state == MRAD_ST_IDLE;
         o_refetch <= state == MRAD_ST_ISB; // [RL21]
         o_fetch_fault <= do_fault; // [RL7]
      end
   end

endmodule : mrad_top
`default_nettype wire

// ==== tb/mrad_bus_model.sv ====
// system bus responder: random stalls, in-order completion pulses
// assumes the issuer holds its request until ready is sampled high
`timescale 1ns/1ps
`default_nettype none
module mrad_bus_model
(
   input wire logic i_clk_sys,
   input wire logic i_nrst,
   input wire logic i_bus_valid,
   input wire logic i_slow,
   output logic o_bus_ready,
   output logic o_bus_done
);
   logic [3:0] pend;
   logic [1:0] roll;
   logic go;
   // one completion per accepted issue, oldest first
   assign go = (pend != 4'h0) && (!i_slow || roll[1]);
   always @(posedge i_clk_sys or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         pend <= 4'h0;
         roll <= 2'h0;
         o_bus_ready <= 1'b0;
         o_bus_done <= 1'b0;
      end
      else
      begin
         roll <= 2'($urandom);
         o_bus_ready <= !i_slow || roll[0];
         o_bus_done <= go;
         pend <= pend + 4'(i_bus_valid && o_bus_ready) - 4'(go);
      end
   end
endmodule : mrad_bus_model
`default_nettype wire

// ==== tb/mrad_top_sva.sv ====
// checker: decode, ordering and barrier properties of mrad_top
// assumes it is bound into mrad_top and sees its ports only
`timescale 1ns/1ps
`default_nettype none
module mrad_top_sva
   import mrad_pkg::*;
#(
   parameter int WBUF_DEPTH = 4,
   parameter int OUTST_MAX = 7
)
(
   input wire logic i_clk_sys,
   input wire logic i_nrst,
   input wire logic i_req_valid,
   input wire mrad_req_s i_req,
   input wire logic o_req_ready,
   input wire mrad_attr_s o_attr,
   input wire logic o_fetch_fault,
   input wire logic i_mpu_en,
   input wire logic i_mpu_hit,
   input wire mrad_attr_s i_mpu_attr,
   input wire logic i_bar_valid,
   input wire mrad_barrier_e i_bar_kind,
   input wire logic o_bar_ready,
   input wire logic o_bar_done,
   input wire logic o_exec_stall,
   input wire logic o_refetch,
   input wire logic o_bus_valid,
   input wire mrad_bus_req_s o_bus_req,
   input wire logic i_bus_ready,
   input wire logic i_bus_done
);
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_nrst);
   logic dflt;
   logic take;
   logic btake;
   logic private_peripheral_range;
   logic [2:0] seg;
   assign dflt = !(i_mpu_en && i_mpu_hit);
   assign take = i_req_valid && o_req_ready;
   assign btake = i_bar_valid && o_bar_ready;
   assign seg = i_req.addr[31:29];
   assign private_peripheral_range = i_req.addr[31:20] == PPB_TAG;
   a_code_normal: assert property (
      dflt && seg == 3'h0 |-> o_attr.mtype == MRAD_NORMAL
      && !o_attr.execute_never) else $error("code decode wrong");
   a_sram_exec: assert property (
      dflt && seg == 3'h1 |-> o_attr.mtype == MRAD_NORMAL
      && !o_attr.execute_never) else $error("sram decode wrong");
   a_periph_dev: assert property (
      dflt && seg == 3'h2 |-> o_attr.mtype == MRAD_DEVICE
      && o_attr.execute_never) else $error("periph decode wrong");
   a_xram_cache: assert property (
      dflt && seg inside {3'h3, 3'h4} |-> !o_attr.execute_never
      && (seg == 3'h3 ? o_attr.cache == MRAD_WRITE_BACK_ALLOCATE
      : o_attr.cache == MRAD_WRITE_THROUGH)) else $error("xram wrong");
   a_xdev_share: assert property (
      dflt && seg inside {3'h5, 3'h6} |-> o_attr.execute_never
      && o_attr.shareable == (seg == 3'h5)) else $error("xdev wrong");
   a_ppb_strong: assert property (
      dflt && private_peripheral_range |-> o_attr.mtype == MRAD_STRONG && o_attr.shareable
      && o_attr.execute_never) else $error("ppb decode wrong");
   a_vendor_dev: assert property (
      dflt && seg == 3'h7 && !private_peripheral_range |-> o_attr.mtype == MRAD_DEVICE
      && o_attr.execute_never) else $error("vendor decode wrong");
   a_mpu_wins: assert property (
      !dflt && i_mpu_attr.mtype != MRAD_STRONG |-> o_attr == i_mpu_attr)
      else $error("override ignored");
   a_strong_share: assert property (
      o_attr.mtype == MRAD_STRONG |-> o_attr.shareable)
      else $error("strong not shareable");
   a_xn_fault: assert property (
      take && i_req.fetch && o_attr.execute_never |=> o_fetch_fault)
      else $error("no fetch fault");
   a_strong_direct: assert property (
      take && !i_req.fetch && o_attr.mtype == MRAD_STRONG |=> o_bus_valid
      && o_bus_req.req.addr == $past(i_req.addr)) else $error("strong late");
   a_bus_hold: assert property (
      o_bus_valid && !i_bus_ready |=> o_bus_valid && $stable(o_bus_req))
      else $error("bus request dropped");
   a_dsb_stall: assert property (
      btake && i_bar_kind == MRAD_BAR_DATA_SYNC |=> o_exec_stall)
      else $error("no stall");
   a_isb_refetch: assert property (
      btake && i_bar_kind == MRAD_BAR_INSTRUCTION_SYNC |-> ##2 o_refetch
      && o_bar_done) else $error("no refetch");
   a_dmb_block: assert property (
      btake && i_bar_kind == MRAD_BAR_DATA_MEMORY |=> !o_req_ready)
      else $error("access during barrier");
   c_fault: cover property (o_fetch_fault);
   c_dsb: cover property (o_exec_stall ##[1:40] o_bar_done);
   c_stall: cover property (o_bus_valid && !i_bus_ready);
endmodule : mrad_top_sva
bind mrad_top mrad_top_sva #(.WBUF_DEPTH(WBUF_DEPTH), .OUTST_MAX(OUTST_MAX))
   u_mrad_top_sva (.*);
`default_nettype wire

// ==== tb/mrad_top_tb.sv ====
// testbench: decode table, override, ordered issue, faults, barriers
// assumes the bus responder model stands on the issue port
`timescale 1ns/1ps
`default_nettype none
module mrad_top_tb;
   import mrad_pkg::*;
   logic i_clk_sys = 1'b0;
   logic i_nrst = 1'b0;
   logic i_req_valid = 1'b0;
   mrad_req_s i_req = '0;
   logic i_mpu_en = 1'b0;
   logic i_mpu_hit = 1'b0;
   mrad_attr_s i_mpu_attr = '0;
   logic i_bar_valid = 1'b0;
   mrad_barrier_e i_bar_kind = MRAD_BAR_DATA_MEMORY;
   logic slow = 1'b1;
   logic o_req_ready, o_fetch_fault, o_bar_ready, o_bar_done;
   logic o_exec_stall, o_refetch, o_bus_valid, i_bus_ready, i_bus_done;
   mrad_attr_s o_attr;
   mrad_attr_s ma;
   mrad_bus_req_s o_bus_req;
   logic [33:0] exp_q [$];
   logic [31:0] a;
   logic [31:0] tbl [4] = '{32'hE00FFFFF, 32'hE0100000, 32'hFFFFFFFF,
      32'h9FFFFFFF};
   int n_errors = 0;
   int cmp_count = 0;
   int cyc = 0;
   mrad_top u_mrad_top (.i_clk_sys, .i_nrst, .i_req_valid, .i_req,
      .o_req_ready, .o_attr, .o_fetch_fault, .i_mpu_en, .i_mpu_hit,
      .i_mpu_attr, .i_bar_valid, .i_bar_kind, .o_bar_ready, .o_bar_done,
      .o_exec_stall, .o_refetch, .o_bus_valid, .o_bus_req, .i_bus_ready,
      .i_bus_done);
   mrad_bus_model u_mrad_bus_model (.i_clk_sys, .i_nrst,
      .i_bus_valid(o_bus_valid), .i_slow(slow), .o_bus_ready(i_bus_ready),
      .o_bus_done(i_bus_done));
   always #2 i_clk_sys = ~i_clk_sys;
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic mrad_attr_s ex(input logic [31:0] x);
      mrad_attr_s e;
      e = '0;
      case (x[31:29])
         3'h0: e.region = MRAD_RG_CODE;
         3'h1: e.region = MRAD_RG_SRAM;
         3'h2: e = '{MRAD_RG_PERIPH, MRAD_DEVICE, 1'b0, MRAD_CACHE_NONE, 1'b1};
         3'h3: e = '{MRAD_RG_XRAM, MRAD_NORMAL, 1'b0,
            MRAD_WRITE_BACK_ALLOCATE, 1'b0};
         3'h4: e = '{MRAD_RG_XRAM, MRAD_NORMAL, 1'b0, MRAD_WRITE_THROUGH, 1'b0};
         3'h5, 3'h6: e = '{MRAD_RG_XDEV, MRAD_DEVICE, !x[30], MRAD_CACHE_NONE,
            1'b1};
         default: e = (x[31:20] == 12'hE00) ?
            '{MRAD_RG_PRIVATE_PERIPHERAL_RANGE, MRAD_STRONG, 1'b1,
            MRAD_CACHE_NONE, 1'b1} :
            '{MRAD_RG_VENDOR, MRAD_DEVICE, 1'b0, MRAD_CACHE_NONE, 1'b1};
      endcase
      return e;
   endfunction : ex
   task automatic check(input logic [33:0] seen, input logic [33:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("Error %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic finish_test;
      $display("compares %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : finish_test
   // request held from a falling edge until taken; fault seen next cycle
   task automatic acc(input logic [31:0] x, input logic wr, input logic fe,
      input logic flt);
      int n;
      n = 0;
      i_req_valid = 1'b1;
      i_req = '{x, 32'($urandom), wr, fe};
      #1;
      while (!o_req_ready && n < 200)
      begin
         @(negedge i_clk_sys);
         #1;
         n++;
      end
      if (!flt)
         exp_q.push_back({x, wr, fe});
      @(negedge i_clk_sys);
      check(34'(o_fetch_fault), 34'(flt));
   endtask : acc
   task automatic bar(input mrad_barrier_e k);
      int n;
      n = 0;
      i_bar_valid = 1'b1;
      i_bar_kind = k;
      while (!o_bar_ready && n < 200)
      begin
         @(negedge i_clk_sys);
         n++;
      end
      @(negedge i_clk_sys);
      i_bar_valid = 1'b0;
      n = 1;
      if (k == MRAD_BAR_DATA_SYNC)
         check(34'(o_exec_stall), 34'h1);
      while (!o_bar_done && n < 100)
      begin
         @(negedge i_clk_sys);
         n++;
      end
      if (k == MRAD_BAR_INSTRUCTION_SYNC)
         check(34'({o_refetch, n[3:0]}), 34'h12);
      else
         check(34'(exp_q.size()), 34'h0);
   endtask : bar
   // ----------------------------------------------------------------
   // result watcher and run limit
   // ----------------------------------------------------------------
   always @(posedge i_clk_sys)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         n_errors++;
         finish_test();
      end
      else if (o_bus_valid && i_bus_ready)
      begin
         if (exp_q.size() == 0)
            check(34'({o_bus_req.req.addr, 2'h0}), 34'h3FFFFFFFF);
         else
         begin
            check({o_bus_req.req.addr, o_bus_req.req.write,
               o_bus_req.req.fetch}, exp_q.pop_front());
            check(34'(o_bus_req.attr), 34'(ex(o_bus_req.req.addr)));
         end
      end
   end
   initial
   begin
      void'($urandom(39));
      repeat (2) @(negedge i_clk_sys);
      i_nrst = 1'b1;
      repeat (4) @(negedge i_clk_sys);
      for (int i = 0; i < 12; i++)
      begin
         a = (i < 8) ? {i[2:0], 29'($urandom)} : tbl[i-8];
         i_req.addr = a;
         #1;
         check(34'(o_attr), 34'(ex(a)));
         @(negedge i_clk_sys);
      end
      $display("test decode done");
      i_mpu_en = 1'b1;
      i_mpu_hit = 1'b1;
      ma = mrad_attr_s'(9'($urandom));
      ma.mtype = MRAD_DEVICE;
      ma.cache = MRAD_WRITE_THROUGH;
      i_mpu_attr = ma;
      #1;
      check(34'(o_attr), 34'(ma));
      @(negedge i_clk_sys);
      ma.mtype = MRAD_STRONG;
      ma.shareable = 1'b0;
      i_mpu_attr = ma;
      #1;
      check(34'(o_attr.shareable), 34'h1);
      @(negedge i_clk_sys);
      i_mpu_hit = 1'b0;
      #1;
      check(34'(o_attr), 34'(ex(a)));
      @(negedge i_clk_sys);
      i_mpu_en = 1'b0;
      $display("test override done");
      acc({8'h40, 24'($urandom)}, 1'b1, 1'b0, 1'b0);
      acc({8'h41, 24'($urandom)}, 1'b1, 1'b0, 1'b0);
      acc(32'hE000ED00, 1'b1, 1'b0, 1'b0);
      acc(32'h50000000, 1'b0, 1'b0, 1'b0);
      acc(32'h20000100, 1'b0, 1'b0, 1'b0);
      acc(32'h00000200, 1'b0, 1'b1, 1'b0);
      acc(32'h40000000, 1'b0, 1'b1, 1'b1);
      acc(32'hE0000010, 1'b0, 1'b1, 1'b1);
      i_req_valid = 1'b0;
      $display("test ordering done");
      for (int k = 0; k < 3; k++)
      begin
         slow = k[0];
         acc({8'h42, 24'($urandom)}, 1'b1, 1'b0, 1'b0);
         acc({8'hC0, 24'($urandom)}, 1'b1, 1'b0, 1'b0);
         i_req_valid = 1'b0;
         bar(mrad_barrier_e'(k));
      end
      repeat (30) @(negedge i_clk_sys);
      check(34'(exp_q.size()), 34'h0);
      $display("test barriers done");
      finish_test();
   end
endmodule : mrad_top_tb
`default_nettype wire
